/* File: src/cgsr_pkg.sv */
package cgsr_pkg;
	// register byte offsets
	localparam logic [7:0] OFF_GATE_SYNC_CFG = 8'h00;
	localparam logic [7:0] OFF_REF_CTRL = 8'h04;
	localparam logic [7:0] OFF_PRESCALE = 8'h08;
	localparam logic [7:0] OFF_STATUS = 8'h0c;
	// comparator_gate_sync_config fields
	localparam int CFG_SYNC_BIT = 0;
	localparam int CFG_GSS_BIT = 1;
	localparam logic [7:0] CFG_RESET = 8'h02;
	// voltage_reference_control fields
	localparam int VR_EN_BIT = 7;
	localparam int VR_RANGE_BIT = 5;
	localparam int VR_LEVEL_LSB = 0;
	localparam logic [7:0] VR_RESET = 8'h00;
	// prescale register field
	localparam int PS_LSB = 0;
	localparam logic [1:0] PS_RESET = 2'h0;
	// ladder tap in 96ths of supply: low = code*4, high = 24 + code*3
	localparam logic [6:0] TAP_HIGH_BASE = 7'h18;
	localparam logic [6:0] TAP_ZERO = 7'h00;

	typedef struct packed {
		logic enable;
		logic range_low;
		logic [3:0] level;
	} cgsr_ladder_t;

	typedef struct packed {
		logic prescaled_clk;
		logic latched_result;
		logic gate_out;
	} cgsr_status_t;
endpackage

/* File: src/cgsr_top.sv */
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
module cgsr_top #(
	parameter int PS_W = 3
) (
	// clock and reset
	input wire logic MCLK,
	input wire logic RESET,
	// apb slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// comparator, gate pin and timer clock
	input wire logic COMPARATOR_RESULT,
	input wire logic EXTERNAL_GATE_PIN,
	input wire logic TIMER_CLK_SRC,
	// toward the gated counter
	output logic GATE_OUT,
	output logic COUNT_INC,
	// toward the resistor ladder
	output cgsr_pkg::cgsr_ladder_t REF_LADDER,
	output logic [6:0] REF_TAP_96
);
	logic sync_r, sync_nxt;
	logic gss_r, gss_nxt;
	logic [1:0] ps_r, ps_nxt;
	cgsr_pkg::cgsr_ladder_t lad_r, lad_nxt;
	logic [6:0] tap_r, tap_nxt;
	logic [PS_W-1:0] cnt_r, cnt_nxt;
	logic tclk_q_r;
	logic pre_q_r;
	logic latch_r, latch_nxt;
	logic inc_r, inc_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic pre_clk, pre_rise, pre_fall, tclk_rise;
	logic wr, setup, hit;
	cgsr_pkg::cgsr_status_t stat;

	assign setup = PSEL && !PENABLE;
	assign wr = PSEL && PENABLE && PWRITE;
	assign hit = (PADDR == cgsr_pkg::OFF_GATE_SYNC_CFG) ||
		(PADDR == cgsr_pkg::OFF_REF_CTRL) ||
		(PADDR == cgsr_pkg::OFF_PRESCALE) ||
		(PADDR == cgsr_pkg::OFF_STATUS);
	// zero wait states; unmapped addresses error in the access phase
	assign PREADY = 1'b1;
	assign PSLVERR = PSEL && PENABLE && !hit;
	assign PRDATA = rdata_r;

	assign tclk_rise = TIMER_CLK_SRC && !tclk_q_r;
	// divide ratio 1,2,4,8; the counter steps on source rising edges
	always_comb begin
		case (ps_r)
			2'h0: pre_clk = TIMER_CLK_SRC;
			2'h1: pre_clk = cnt_r[0];
			2'h2: pre_clk = cnt_r[1];
			2'h3: pre_clk = cnt_r[2];
			default: pre_clk = TIMER_CLK_SRC;
		endcase
	end
	assign pre_rise = pre_clk && !pre_q_r;
	assign pre_fall = !pre_clk && pre_q_r;

	// async path stays combinational so no increment waits a cycle
	always_comb begin
		if (gss_r) begin
			GATE_OUT = EXTERNAL_GATE_PIN;
		end else if (sync_r) begin
			GATE_OUT = latch_r;
		end else begin
			GATE_OUT = COMPARATOR_RESULT;
		end
	end
	assign COUNT_INC = inc_r;
	assign REF_LADDER = lad_r;
	assign REF_TAP_96 = tap_r;

	assign stat.prescaled_clk = pre_q_r;
	assign stat.latched_result = latch_r;
	assign stat.gate_out = GATE_OUT;

	always_comb begin
		sync_nxt = sync_r;
		gss_nxt = gss_r;
		ps_nxt = ps_r;
		lad_nxt = lad_r;
		rdata_nxt = rdata_r;
		cnt_nxt = cnt_r;
		latch_nxt = latch_r;
		// counter side acts on the rising edge only
		inc_nxt = pre_rise;
		if (tclk_rise) begin
			cnt_nxt = cnt_r + 1'b1;
		end
		// latch only on the falling edge, half a period from the count
		if (pre_fall) begin
			latch_nxt = COMPARATOR_RESULT;
		end
		if (wr) begin
			// only implemented bits are taken
			case (PADDR)
				cgsr_pkg::OFF_GATE_SYNC_CFG: begin
					sync_nxt = PWDATA[cgsr_pkg::CFG_SYNC_BIT];
					gss_nxt = PWDATA[cgsr_pkg::CFG_GSS_BIT];
				end
				cgsr_pkg::OFF_REF_CTRL: begin
					lad_nxt.enable = PWDATA[cgsr_pkg::VR_EN_BIT];
					lad_nxt.range_low = PWDATA[cgsr_pkg::VR_RANGE_BIT];
					lad_nxt.level = PWDATA[cgsr_pkg::VR_LEVEL_LSB +: 4];
				end
				cgsr_pkg::OFF_PRESCALE: begin
					ps_nxt = PWDATA[cgsr_pkg::PS_LSB +: 2];
				end
				default: begin
					ps_nxt = ps_r;
				end
			endcase
		end
		if (setup) begin
			rdata_nxt = 32'h0;
			case (PADDR)
				cgsr_pkg::OFF_GATE_SYNC_CFG: begin
					rdata_nxt[cgsr_pkg::CFG_SYNC_BIT] = sync_r;
					rdata_nxt[cgsr_pkg::CFG_GSS_BIT] = gss_r;
				end
				cgsr_pkg::OFF_REF_CTRL: begin
					rdata_nxt[cgsr_pkg::VR_EN_BIT] = lad_r.enable;
					rdata_nxt[cgsr_pkg::VR_RANGE_BIT] = lad_r.range_low;
					rdata_nxt[cgsr_pkg::VR_LEVEL_LSB +: 4] = lad_r.level;
				end
				cgsr_pkg::OFF_PRESCALE: begin
					rdata_nxt[cgsr_pkg::PS_LSB +: 2] = ps_r;
				end
				cgsr_pkg::OFF_STATUS: begin
					rdata_nxt[2:0] = stat;
				end
				default: begin
					rdata_nxt = 32'h0;
				end
			endcase
		end
		// tap follows the new register value at the same edge
		if (!lad_nxt.enable) begin
			tap_nxt = cgsr_pkg::TAP_ZERO;
		end else if (lad_nxt.range_low) begin
			tap_nxt = {1'b0, lad_nxt.level, 2'b00};
		end else begin
			tap_nxt = cgsr_pkg::TAP_HIGH_BASE + {2'b00, lad_nxt.level, 1'b0} +
				{3'b000, lad_nxt.level};
		end
	end

	always_ff @(posedge MCLK) begin
		if (RESET) begin
			sync_r <= cgsr_pkg::CFG_RESET[cgsr_pkg::CFG_SYNC_BIT];
			gss_r <= cgsr_pkg::CFG_RESET[cgsr_pkg::CFG_GSS_BIT];
			ps_r <= cgsr_pkg::PS_RESET;
			lad_r <= cgsr_pkg::cgsr_ladder_t'({cgsr_pkg::VR_RESET[cgsr_pkg::VR_EN_BIT],
				cgsr_pkg::VR_RESET[cgsr_pkg::VR_RANGE_BIT],
				cgsr_pkg::VR_RESET[cgsr_pkg::VR_LEVEL_LSB +: 4]});
			tap_r <= cgsr_pkg::TAP_ZERO;
			cnt_r <= '0;
			tclk_q_r <= 1'b0;
			pre_q_r <= 1'b0;
			latch_r <= 1'b0;
			inc_r <= 1'b0;
			rdata_r <= 32'h0;
		end else begin
			sync_r <= sync_nxt;
			gss_r <= gss_nxt;
			ps_r <= ps_nxt;
			lad_r <= lad_nxt;
			tap_r <= tap_nxt;
			cnt_r <= cnt_nxt;
			tclk_q_r <= TIMER_CLK_SRC;
			pre_q_r <= pre_clk;
			latch_r <= latch_nxt;
			inc_r <= inc_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	default clocking cb @(posedge MCLK); endclocking
	default disable iff (RESET);

	property p_latch_on_fall;
		pre_fall |=> latch_r == $past(COMPARATOR_RESULT);
	endproperty
	a_latch_on_fall: assert property (p_latch_on_fall) else $error("latch missed fall");

	property p_latch_only_fall;
		!pre_fall |=> $stable(latch_r);
	endproperty
	a_latch_only_fall: assert property (p_latch_only_fall) else $error("latch moved");

	property p_inc_on_rise;
		COUNT_INC |-> $past(pre_rise) && !$past(pre_fall);
	endproperty
	a_inc_on_rise: assert property (p_inc_on_rise) else $error("increment off edge");

	property p_sync_path;
		sync_r && !gss_r |-> GATE_OUT == latch_r;
	endproperty
	a_sync_path: assert property (p_sync_path) else $error("sync path wrong");

	property p_async_path;
		!sync_r && !gss_r |-> GATE_OUT == COMPARATOR_RESULT;
	endproperty
	a_async_path: assert property (p_async_path) else $error("async path wrong");

	property p_pin_path;
		gss_r |-> GATE_OUT == EXTERNAL_GATE_PIN;
	endproperty
	a_pin_path: assert property (p_pin_path) else $error("pin path wrong");

	property p_cfg_zero;
		PSEL && PENABLE && !PWRITE && PADDR == cgsr_pkg::OFF_GATE_SYNC_CFG
			|-> PRDATA[31:2] == 30'h0;
	endproperty
	a_cfg_zero: assert property (p_cfg_zero) else $error("config high bits set");

	property p_ref_zero;
		PSEL && PENABLE && !PWRITE && PADDR == cgsr_pkg::OFF_REF_CTRL
			|-> PRDATA[6] == 1'b0 && PRDATA[4] == 1'b0 && PRDATA[31:8] == 24'h0;
	endproperty
	a_ref_zero: assert property (p_ref_zero) else $error("reference unused bits set");

	property p_off_ground;
		!REF_LADDER.enable |-> REF_TAP_96 == 7'h00;
	endproperty
	a_off_ground: assert property (p_off_ground) else $error("tap not grounded");

	property p_low_tap;
		REF_LADDER.enable && REF_LADDER.range_low
			|-> REF_TAP_96 == {1'b0, REF_LADDER.level, 2'b00};
	endproperty
	a_low_tap: assert property (p_low_tap) else $error("low range tap wrong");

	property p_ref_write;
		wr && PADDR == cgsr_pkg::OFF_REF_CTRL |=>
			REF_LADDER == {$past(PWDATA[7]), $past(PWDATA[5]), $past(PWDATA[3:0])};
	endproperty
	a_ref_write: assert property (p_ref_write) else $error("ladder not updated");

	property p_cfg_write;
		wr && PADDR == cgsr_pkg::OFF_GATE_SYNC_CFG |=>
			gss_r == $past(PWDATA[1]) && sync_r == $past(PWDATA[0]);
	endproperty
	a_cfg_write: assert property (p_cfg_write) else $error("config not updated");

	property p_high_tap;
		REF_LADDER.enable && !REF_LADDER.range_low |->
			REF_TAP_96 == cgsr_pkg::TAP_HIGH_BASE + {2'b00, REF_LADDER.level, 1'b0} +
			{3'b000, REF_LADDER.level};
	endproperty
	a_high_tap: assert property (p_high_tap) else $error("high range tap wrong");

	property p_off_write;
		wr && PADDR == cgsr_pkg::OFF_REF_CTRL && !PWDATA[cgsr_pkg::VR_EN_BIT]
			|=> REF_TAP_96 == cgsr_pkg::TAP_ZERO;
	endproperty
	a_off_write: assert property (p_off_write) else $error("tap not cleared");

	// registers move only on their own write; any other change is a decode leak
	property p_ref_hold;
		!(wr && PADDR == cgsr_pkg::OFF_REF_CTRL) |=> $stable(REF_LADDER) && $stable(REF_TAP_96);
	endproperty
	a_ref_hold: assert property (p_ref_hold) else $error("ladder moved");

	property p_cfg_hold;
		!(wr && PADDR == cgsr_pkg::OFF_GATE_SYNC_CFG) |=> $stable(sync_r) && $stable(gss_r);
	endproperty
	a_cfg_hold: assert property (p_cfg_hold) else $error("config moved");

	// the counting edge must never disturb the latch, or the gate could race the increment
	property p_latch_hold_rise;
		pre_rise |=> $stable(latch_r);
	endproperty
	a_latch_hold_rise: assert property (p_latch_hold_rise) else $error("latch moved on rise");

	c_sync_gate: cover property (sync_r && !gss_r && COUNT_INC && GATE_OUT);
	c_ps_fall: cover property (ps_r != 2'h0 && pre_fall);
	c_pin_gate: cover property (gss_r && EXTERNAL_GATE_PIN);
	c_high_tap: cover property (REF_LADDER.enable && !REF_LADDER.range_low && REF_TAP_96 == 7'h45);
	c_err: cover property (PSLVERR);
endmodule

/* File: tb/cgsr_cnt_model.sv */
`timescale 1ns/1ns
module cgsr_cnt_model (
	// clock and reset
	input wire logic mclk,
	input wire logic reset,
	// from the block
	input wire logic gate,
	input wire logic inc,
	// count seen by the bench
	output logic [15:0] count_r
);
	logic [15:0] count_nxt;
	// the gate is judged at the increment, as the gated counter would
	always_comb begin
		count_nxt = count_r;
		if (gate && inc) begin
			count_nxt = count_r + 16'h0001;
		end
	end
	always_ff @(posedge mclk) begin
		count_r <= reset ? 16'h0000 : count_nxt;
	end
endmodule

/* File: tb/test_comparator_sync_and_reference_control.sv */
`timescale 1ns/1ns
module test_comparator_sync_and_reference_control;
	logic mclk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
	logic comp = 1'b0, pin = 1'b0, tclk = 1'b0, pready, perr, perr_s, gate, inc;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [6:0] tap;
	logic [15:0] cnt, c0;
	cgsr_pkg::cgsr_ladder_t ladder;
	int bad_count = 0, n_tests = 0;
	always #50 mclk = ~mclk;
	cgsr_top #(.PS_W(3)) u_cgsr_top (.MCLK(mclk), .RESET(rst), .PSEL(psel), .PENABLE(pen),
		.PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(perr), .COMPARATOR_RESULT(comp), .EXTERNAL_GATE_PIN(pin),
		.TIMER_CLK_SRC(tclk), .GATE_OUT(gate), .COUNT_INC(inc), .REF_LADDER(ladder),
		.REF_TAP_96(tap));
	cgsr_cnt_model u_cgsr_cnt_model (.mclk(mclk), .reset(rst), .gate(gate), .inc(inc),
		.count_r(cnt));
	task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task report_and_stop;
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// one edge is left idle after each transfer so psel is never set twice in a step
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		pen <= 1'b1;
		// no wait limit here: a slave that never answers is left to the watchdog
		do begin
			@(posedge mclk);
		end while (pready !== 1'b1);
		rd = prdata;
		perr_s = perr;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge mclk);
	endtask
	task step(input logic v);
		tclk <= v;
		repeat (3) @(posedge mclk);
	endtask
	task t_regs;
		apb(1'b0, cgsr_pkg::OFF_GATE_SYNC_CFG, 32'h0);
		chk("cfg reset", rd, {24'h0, cgsr_pkg::CFG_RESET});
		chk("mapped err", {31'h0, perr_s}, 32'h0);
		apb(1'b0, cgsr_pkg::OFF_REF_CTRL, 32'h0);
		chk("ref reset", rd, {24'h0, cgsr_pkg::VR_RESET});
		apb(1'b1, cgsr_pkg::OFF_GATE_SYNC_CFG, 32'hffffffff);
		apb(1'b0, cgsr_pkg::OFF_GATE_SYNC_CFG, 32'h0);
		chk("cfg bits", rd, 32'h3);
		apb(1'b1, cgsr_pkg::OFF_REF_CTRL, 32'hffffffff);
		apb(1'b0, cgsr_pkg::OFF_REF_CTRL, 32'h0);
		chk("ref bits", rd, 32'haf);
		chk("ladder all", {26'h0, ladder}, 32'h3f);
		apb(1'b1, cgsr_pkg::OFF_REF_CTRL, 32'h20);
		chk("tap off", {25'h0, tap}, 32'h0);
		chk("ladder off", {26'h0, ladder}, 32'h10);
		apb(1'b1, cgsr_pkg::OFF_REF_CTRL, 32'h85);
		apb(1'b1, cgsr_pkg::OFF_GATE_SYNC_CFG, 32'h0);
		chk("ladder kept", {26'h0, ladder}, 32'h25);
		apb(1'b1, 8'h10, 32'hffffffff);
		apb(1'b0, 8'h10, 32'h0);
		chk("unmapped rd", rd, 32'h0);
		chk("unmapped err", {31'h0, perr_s}, 32'h1);
		chk("ladder unmapped", {26'h0, ladder}, 32'h25);
		$display("test registers done");
	endtask
	task t_tap;
		logic [31:0] e;
		for (int r = 0; r < 2; r++) begin
			for (int c = 0; c < 16; c++) begin
				apb(1'b1, cgsr_pkg::OFF_REF_CTRL, 32'h80 | (r << 5) | c);
				e = r ? c * 4 : 24 + c * 3;
				chk("tap", {25'h0, tap}, e);
			end
		end
		$display("test ladder taps done");
	endtask
	task t_gate;
		apb(1'b1, cgsr_pkg::OFF_GATE_SYNC_CFG, 32'h2);
		pin <= 1'b1;
		repeat (2) @(posedge mclk);
		chk("pin gate", {31'h0, gate}, 32'h1);
		pin <= 1'b0;
		apb(1'b1, cgsr_pkg::OFF_GATE_SYNC_CFG, 32'h0);
		comp <= 1'b1;
		repeat (2) @(posedge mclk);
		chk("raw gate", {31'h0, gate}, 32'h1);
		comp <= 1'b0;
		apb(1'b1, cgsr_pkg::OFF_GATE_SYNC_CFG, 32'h1);
		step(1'b1);
		step(1'b0);
		c0 = cnt;
		comp <= 1'b1;
		step(1'b1);
		chk("held latch", {31'h0, gate}, 32'h0);
		step(1'b0);
		chk("fall latch", {31'h0, gate}, 32'h1);
		step(1'b1);
		chk("count", {16'h0, cnt}, {16'h0, c0 + 16'h0001});
		apb(1'b1, cgsr_pkg::OFF_PRESCALE, 32'h1);
		comp <= 1'b0;
		repeat (2) begin
			step(1'b0);
			step(1'b1);
		end
		comp <= 1'b1;
		step(1'b0);
		chk("ps hold", {31'h0, gate}, 32'h0);
		repeat (2) begin
			step(1'b1);
			step(1'b0);
		end
		chk("ps latch", {31'h0, gate}, 32'h1);
		apb(1'b1, cgsr_pkg::OFF_GATE_SYNC_CFG, 32'h2);
		pin <= 1'b1;
		c0 = cnt;
		repeat (4) begin
			step(1'b1);
			step(1'b0);
		end
		chk("ps count", {16'h0, cnt}, {16'h0, c0 + 16'h0002});
		apb(1'b0, cgsr_pkg::OFF_PRESCALE, 32'h0);
		chk("ps read", rd, 32'h1);
		// eleven source rises leave the divided clock high; latch and pin gate are both 1
		apb(1'b0, cgsr_pkg::OFF_STATUS, 32'h0);
		chk("status", rd, 32'h7);
		$display("test gate path done");
	endtask
	task t_reset;
		rst <= 1'b1;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		chk("tap rst", {25'h0, tap}, 32'h0);
		chk("ladder rst", {26'h0, ladder}, 32'h0);
		chk("gate rst", {31'h0, gate}, 32'h1);
		apb(1'b0, cgsr_pkg::OFF_GATE_SYNC_CFG, 32'h0);
		chk("cfg rst", rd, {24'h0, cgsr_pkg::CFG_RESET});
		$display("test reset done");
	endtask
	initial begin
		repeat (8) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		t_regs;
		t_tap;
		t_gate;
		t_reset;
		report_and_stop;
	end
	// the tests need well under a thousand cycles
	initial begin
		repeat (5000) @(posedge mclk);
		bad_count++;
		report_and_stop;
	end
endmodule
